// [verilog/pin_change_irq_regs.svh]
// register offsets, field positions and reset values of the pin-change interrupt block
`ifndef PIN_CHANGE_IRQ_REGS_SVH
`define PIN_CHANGE_IRQ_REGS_SVH

// ==========================================================================
// offsets
`define OFS_GROUP_ENABLE 8'h68
`define OFS_MASK_GROUP0 8'h6B
`define OFS_MASK_GROUP1 8'h6C
`define OFS_MASK_GROUP2 8'h6D
`define OFS_GROUP_FLAGS 8'h6E
`define OFS_EXT_IRQ_CTRL 8'h69
`define OFS_EXT_IRQ_ENABLE 8'h3D
`define OFS_EXT_IRQ_FLAGS 8'h3C
`define OFS_IRQ_STATUS 8'h70
`define OFS_IRQ_MASK 8'h71

// ==========================================================================
// fields and reset values
`define GROUP_BITS 3
`define MASK1_VALID 8'h7F
`define SENSE_LOW 2'h0
`define SENSE_ANY 2'h1
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3
`define REG_RESET 8'h00

`endif

// [verilog/pin_change_irq_pkg.sv]
// types shared by the pin-change interrupt block
package pin_change_irq_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic ext0;
    logic [2:0] group;
  } vec_t;

endpackage

// [verilog/pin_change_interrupt_logic.sv]
// flag, enable and mask logic for pin-change and external interrupt 0
// Functional notes
// - set ext0 flag on selected sense event
// - ext0 flag, enable, global enable vector
// - flag cleared when handler starts
// - low level sense holds ext0 flag clear
// - group enable bits 2:0, upper zero
// - group 2 pins raise group2 vector
// - group 1 pins raise group1 vector
// - group 0 pins raise group0 vector
// - group change sets matching group flag
// - flag, enable, global enable vector
// - write one clears flag, zero keeps
// - detect only when mask and group enabled
// - group1 mask bit 7 reads zero
// - flag register bits 7:3 read zero
// - pin changes detected only through the clk_sys synchronisers
// - sense codes low, any, fall, rise
`include "pin_change_irq_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module pin_change_interrupt_logic (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire pin_change_irq_pkg::reg_req_t busReq,
  output logic [7:0] rdData,
  // pins
  input wire logic [23:0] pinIn,
  input wire logic extPin0,
  // core
  input wire logic globalEnable,
  input wire pin_change_irq_pkg::vec_t handlerAck,
  output pin_change_irq_pkg::vec_t vectorReq,
  output logic irqOut
);

  // ==========================================================================
  // synchronisers, three stages
  logic [24:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {extPin0, pinIn};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // stable level follows only when stages two and three agree
  logic [24:0] lvl_q;
  logic lvlInit_q;
  // wait until stage three holds a real pin sample, so no false edge after reset
  logic [1:0] warm_q;
  wire [24:0] agree = ~(s2_q ^ s3_q);
  wire [24:0] lvlNext = (agree & s3_q) | (~agree & lvl_q);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lvl_q <= '0;
      lvlInit_q <= 1'b0;
      warm_q <= 2'h0;
    end else begin
      lvl_q <= lvlInit_q ? lvlNext : s3_q;
      lvlInit_q <= (warm_q == 2'h3);
      warm_q <= (warm_q == 2'h3) ? warm_q : warm_q + 2'h1;
    end
  end
  wire [24:0] chg = lvlInit_q ? (lvlNext ^ lvl_q) : 25'h0;

  // ==========================================================================
  // registers
  logic [2:0] grpEn_q, grpFlag_q;
  logic [7:0] mask0_q, mask1_q, mask2_q;
  logic [1:0] sense_q;
  logic ext0En_q, ext0Flag_q;
  logic [3:0] irqMask_q, irqStat_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic s);
    hit = s && (a == ofs);
  endfunction

  wire wrEn = hit(busReq.addr, `OFS_GROUP_ENABLE, busReq.wr);
  wire wrM0 = hit(busReq.addr, `OFS_MASK_GROUP0, busReq.wr);
  wire wrM1 = hit(busReq.addr, `OFS_MASK_GROUP1, busReq.wr);
  wire wrM2 = hit(busReq.addr, `OFS_MASK_GROUP2, busReq.wr);
  wire wrFl = hit(busReq.addr, `OFS_GROUP_FLAGS, busReq.wr);
  wire wrCt = hit(busReq.addr, `OFS_EXT_IRQ_CTRL, busReq.wr);
  wire wrXe = hit(busReq.addr, `OFS_EXT_IRQ_ENABLE, busReq.wr);
  wire wrXf = hit(busReq.addr, `OFS_EXT_IRQ_FLAGS, busReq.wr);
  wire wrIm = hit(busReq.addr, `OFS_IRQ_MASK, busReq.wr);
  wire rdSt = hit(busReq.addr, `OFS_IRQ_STATUS, busReq.rd);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      grpEn_q <= '0;
      mask0_q <= `REG_RESET;
      mask1_q <= `REG_RESET;
      mask2_q <= `REG_RESET;
      sense_q <= `SENSE_LOW;
      ext0En_q <= 1'b0;
      irqMask_q <= '0;
    end else begin
      if (wrEn) grpEn_q <= busReq.wdata[2:0];
      if (wrM0) mask0_q <= busReq.wdata;
      if (wrM1) mask1_q <= busReq.wdata & `MASK1_VALID;
      if (wrM2) mask2_q <= busReq.wdata;
      if (wrCt) sense_q <= busReq.wdata[1:0];
      if (wrXe) ext0En_q <= busReq.wdata[0];
      if (wrIm) irqMask_q <= busReq.wdata[3:0];
    end
  end

  // ==========================================================================
  // group change detection
  wire [23:0] pinMask = {mask2_q, 1'b0, mask1_q[6:0], mask0_q};
  wire [23:0] grpExpand = {{8{grpEn_q[2]}}, {8{grpEn_q[1]}}, {8{grpEn_q[0]}}};
  wire [23:0] liveChg = chg[23:0] & pinMask & grpExpand;
  wire [2:0] grpEvt;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gGroup
      assign grpEvt[g] = |liveChg[g*8 +: 8];
    end
  endgenerate

  // set wins over software clear and handler acknowledge
  wire [2:0] grpClr = (wrFl ? busReq.wdata[2:0] : 3'h0) | handlerAck.group;
  wire [2:0] grpFlagD = grpEvt | (grpFlag_q & ~grpClr);

  // ==========================================================================
  // external interrupt 0 sense
  wire prevPin = lvl_q[24];
  wire nowPin = lvlNext[24];
  logic ext0Evt;
  always_comb begin
    ext0Evt = 1'b0;
    case (sense_q)
      `SENSE_ANY: ext0Evt = chg[24];
      `SENSE_FALL: ext0Evt = chg[24] & prevPin & ~nowPin;
      `SENSE_RISE: ext0Evt = chg[24] & ~prevPin & nowPin;
      default: ext0Evt = 1'b0;
    endcase
  end
  wire levelMode = (sense_q == `SENSE_LOW);
  wire ext0Clr = (wrXf & busReq.wdata[0]) | handlerAck.ext0;
  wire ext0FlagD = levelMode ? 1'b0 : (ext0Evt | (ext0Flag_q & ~ext0Clr));
  // level sense requests straight from the held low level
  wire levelReq = levelMode & lvlInit_q & ~lvl_q[24];

  // ==========================================================================
  // interrupt status, cleared by read, new events win
  wire [3:0] statEvt = {ext0Evt & ~levelMode, grpEvt};
  wire [3:0] statD = statEvt | (rdSt ? 4'h0 : irqStat_q);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      grpFlag_q <= '0;
      ext0Flag_q <= 1'b0;
      irqStat_q <= '0;
    end else begin
      grpFlag_q <= grpFlagD;
      ext0Flag_q <= ext0FlagD;
      irqStat_q <= statD;
    end
  end

  // ==========================================================================
  // vector requests and read data
  pin_change_irq_pkg::vec_t vecD;
  assign vecD.group = grpFlag_q & grpEn_q & {3{globalEnable}};
  assign vecD.ext0 = (ext0Flag_q | levelReq) & ext0En_q & globalEnable;

  logic [7:0] rdD;
  always_comb begin
    rdD = 8'h00;
    case (busReq.addr)
      `OFS_GROUP_ENABLE: rdD = {5'h00, grpEn_q};
      `OFS_MASK_GROUP0: rdD = mask0_q;
      `OFS_MASK_GROUP1: rdD = mask1_q;
      `OFS_MASK_GROUP2: rdD = mask2_q;
      `OFS_GROUP_FLAGS: rdD = {5'h00, grpFlag_q};
      `OFS_EXT_IRQ_CTRL: rdD = {6'h00, sense_q};
      `OFS_EXT_IRQ_ENABLE: rdD = {7'h00, ext0En_q};
      `OFS_EXT_IRQ_FLAGS: rdD = {7'h00, ext0Flag_q};
      `OFS_IRQ_STATUS: rdD = {4'h0, irqStat_q};
      `OFS_IRQ_MASK: rdD = {4'h0, irqMask_q};
      default: rdD = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdData <= 8'h00;
      vectorReq <= '0;
      irqOut <= 1'b0;
    end else begin
      rdData <= busReq.rd ? rdD : 8'h00;
      vectorReq <= vecD;
      irqOut <= |(statD & irqMask_q);
    end
  end

  // ==========================================================================
  // checks
  property p_grp_set;
    @(posedge clk_sys) disable iff (srst) grpEvt[0] |=> grpFlag_q[0];
  endproperty
  a_grp_set: assert property (p_grp_set) else $error("group0 flag not set");

  property p_w1c;
    @(posedge clk_sys) disable iff (srst)
      (wrFl && busReq.wdata[1] && !grpEvt[1]) |=> !grpFlag_q[1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("group1 flag not cleared");

  property p_w0keep;
    @(posedge clk_sys) disable iff (srst)
      (grpFlag_q[2] && wrFl && !busReq.wdata[2] && !handlerAck.group[2]) |=> grpFlag_q[2];
  endproperty
  a_w0keep: assert property (p_w0keep) else $error("group2 flag lost");

  property p_ack;
    @(posedge clk_sys) disable iff (srst)
      (handlerAck.group[0] && !grpEvt[0]) |=> !grpFlag_q[0];
  endproperty
  a_ack: assert property (p_ack) else $error("ack did not clear");

  property p_level;
    @(posedge clk_sys) disable iff (srst) levelMode |=> !ext0Flag_q;
  endproperty
  a_level: assert property (p_level) else $error("ext0 flag in level mode");

  property p_vec;
    @(posedge clk_sys) disable iff (srst)
      (grpFlag_q[1] && grpEn_q[1] && globalEnable) |=> vectorReq.group[1];
  endproperty
  a_vec: assert property (p_vec) else $error("group1 vector missing");

  property p_mask;
    @(posedge clk_sys) disable iff (srst) !mask0_q[3] |-> !liveChg[3];
  endproperty
  a_mask: assert property (p_mask) else $error("masked pin counted");

  property p_rsvd;
    @(posedge clk_sys) disable iff (srst)
      (busReq.rd && busReq.addr == `OFS_MASK_GROUP1) |=> !rdData[7];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("mask1 bit7 not zero");

  property p_rise;
    @(posedge clk_sys) disable iff (srst)
      (sense_q == `SENSE_RISE && ext0Evt) |-> (!prevPin && nowPin);
  endproperty
  a_rise: assert property (p_rise) else $error("rise sense wrong");

  property p_ext_vec;
    @(posedge clk_sys) disable iff (srst)
      (ext0Flag_q && ext0En_q && globalEnable) |=> vectorReq.ext0;
  endproperty
  a_ext_vec: assert property (p_ext_vec) else $error("ext0 vector missing");

  c_grp2: cover property (@(posedge clk_sys) disable iff (srst) vectorReq.group[2]);
  c_ext0: cover property (@(posedge clk_sys) disable iff (srst) vectorReq.ext0 && !levelMode);
  c_race: cover property (@(posedge clk_sys) disable iff (srst) grpEvt[0] && grpClr[0]);
  c_irq: cover property (@(posedge clk_sys) disable iff (srst) irqOut);

endmodule // pin_change_interrupt_logic

`default_nettype wire

// [tb/core_model.sv]
// core side model: takes one pending vector after a set delay
`timescale 1ns/100ps
`default_nettype none

module core_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // vectoring
  input wire logic [3:0] delay,
  input wire pin_change_irq_pkg::vec_t vectorReq,
  output pin_change_irq_pkg::vec_t handlerAck
);
  logic [3:0] waitQ;
  logic [3:0] reqVec;
  logic [3:0] pick;
  assign reqVec = vectorReq;
  // lowest pending vector wins
  assign pick = reqVec & (~reqVec + 4'h1);

  // delay must stay >= 2 so a stale request is not taken twice
  always_ff @(posedge clk_sys) begin
    handlerAck <= '0;
    waitQ <= (waitQ == 4'hF) ? waitQ : waitQ + 4'h1;
    if (srst || reqVec == 4'h0) begin
      waitQ <= 4'h0;
    end else if (waitQ >= delay) begin
      handlerAck <= pin_change_irq_pkg::vec_t'(pick);
      waitQ <= 4'h0;
    end
  end
endmodule // core_model
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the pin-change interrupt block
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  pin_change_irq_pkg::reg_req_t busReq = '0;
  logic [7:0] rdData;
  logic [23:0] pinIn = '0;
  logic extPin0 = 1'b1;
  logic globalEnable = 1'b0;
  logic [3:0] ackDelay = 4'h3;
  pin_change_irq_pkg::vec_t handlerAck;
  pin_change_irq_pkg::vec_t vectorReq;
  logic irqOut;
  logic sawVec = 1'b0;
  logic sawExt = 1'b0;
  int n_fail = 0;
  int checked = 0;
  int pins [3] = '{7, 8, 23};
  // address, write value, read back
  logic [23:0] rows [10] = '{24'h68FF07, 24'h6BA5A5, 24'h6CFF7F, 24'h6D5A5A, 24'h6EFF00,
    24'h690101, 24'h3D0101, 24'h710F0F, 24'h50FF00, 24'h3CFF00};
  // sense, from level, to level, flag expected
  logic [4:0] ext [5] = '{5'b01101, 5'b10101, 5'b11100, 5'b11011, 5'b10010};

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (vectorReq.group[0] === 1'b1) sawVec <= 1'b1;
  always @(posedge clk_sys) if (vectorReq.ext0 === 1'b1 && extPin0 === 1'b0) sawExt <= 1'b1;

  pin_change_interrupt_logic i_dut (.clk_sys(clk_sys), .srst(srst), .busReq(busReq),
    .rdData(rdData), .pinIn(pinIn), .extPin0(extPin0), .globalEnable(globalEnable),
    .handlerAck(handlerAck), .vectorReq(vectorReq), .irqOut(irqOut));
  core_model i_core (.clk_sys(clk_sys), .srst(srst), .delay(ackDelay),
    .vectorReq(vectorReq), .handlerAck(handlerAck));

  // ==========================================================================
  // tasks
  task automatic chkByte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkBit(input string name, input logic exp, input logic got);
    chkByte(name, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
  endtask
  task automatic rdChk(input string name, input logic [7:0] exp, input logic [7:0] a);
    @(posedge clk_sys);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
    #1 chkByte(name, exp, rdData);
  endtask
  task automatic tog(input int p);
    @(posedge clk_sys);
    pinIn[p] <= ~pinIn[p];
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // sequence
  initial begin
    idle(16);
    srst <= 1'b0;
    idle(4);
    foreach (rows[i]) begin
      rdChk("reset value", 8'h00, rows[i][23:16]);
      regWr(rows[i][23:16], rows[i][15:8]);
      rdChk("read back", rows[i][7:0], rows[i][23:16]);
    end
    regWr(8'h6B, 8'hFF);
    regWr(8'h6C, 8'h7F);
    regWr(8'h6D, 8'hFF);
    for (int g = 0; g < 3; g++) begin
      tog(pins[g]);
      idle(8);
      rdChk("group flag", 8'h01 << g, 8'h6E);
      chkBit("no vector", 1'b0, vectorReq.group[g]);
      regWr(8'h6E, 8'h00);
      rdChk("flag kept", 8'h01 << g, 8'h6E);
      regWr(8'h6E, 8'h01 << g);
      rdChk("flag cleared", 8'h00, 8'h6E);
    end
    chkBit("irq", 1'b1, irqOut);
    rdChk("status", 8'h07, 8'h70);
    idle(2);
    chkBit("irq after read", 1'b0, irqOut);
    // masked pin, then disabled group
    regWr(8'h6B, 8'hFE);
    tog(0);
    idle(8);
    rdChk("masked pin", 8'h00, 8'h6E);
    regWr(8'h68, 8'h06);
    tog(1);
    idle(8);
    rdChk("group off", 8'h00, 8'h6E);
    regWr(8'h68, 8'h07);
    regWr(8'h71, 8'h00);
    foreach (ext[i]) begin
      @(posedge clk_sys) extPin0 <= ext[i][2];
      idle(6);
      regWr(8'h69, {6'h00, ext[i][4:3]});
      regWr(8'h3C, 8'h01);
      @(posedge clk_sys) extPin0 <= ext[i][1];
      idle(8);
      rdChk("ext flag", {7'h00, ext[i][0]}, 8'h3C);
    end
    regWr(8'h69, 8'h00);
    @(posedge clk_sys) extPin0 <= 1'b0;
    idle(8);
    rdChk("level flag", 8'h00, 8'h3C);
    chkBit("irq masked", 1'b0, irqOut);
    rdChk("ext status", 8'h08, 8'h70);
    @(posedge clk_sys) extPin0 <= 1'b1;
    // core takes the vector promptly, then slowly
    globalEnable <= 1'b1;
    tog(2);
    idle(12);
    chkBit("vector seen", 1'b1, sawVec);
    rdChk("acked flag", 8'h00, 8'h6E);
    ackDelay <= 4'h9;
    tog(3);
    idle(6);
    rdChk("pending flag", 8'h01, 8'h6E);
    idle(12);
    rdChk("slow acked flag", 8'h00, 8'h6E);
    // external interrupt 0 edge taken by the core
    regWr(8'h69, 8'h01);
    @(posedge clk_sys) extPin0 <= 1'b0;
    idle(20);
    chkBit("ext vector", 1'b1, sawExt);
    rdChk("ext acked flag", 8'h00, 8'h3C);
    results();
  end

  initial begin
    idle(5000);
    n_fail++;
    results();
  end
endmodule // testbench
`default_nettype wire
